// file: src/mpmi_pins.sv
// pin direction, clocking and data muxing for external mac ports 7 and 6
//
// Behaviour
// - mii transmit clock 25/2.5 mhz: driven by device as phy, input as mac
// - mii receive clock 25/2.5 mhz: device output as phy, input as mac
// - rmii normal: far party feeds 50 mhz reference; ignored in rmii clock mode
// - rmii clock mode: device drives 50 mhz reference out on receive clock pin
// - rgmii: device drives receive clock out at 100/25/2.5 mhz by speed, 125 rounding to 100
// - transmit error is an input only in mii mode, otherwise unused
// - mii collision: output as phy, input as mac; unused in rmii/rgmii
// - transmit data four bits in mii/rgmii, only two low bits in rmii
// - mii: device drives receive data valid qualifying receive data
// - rmii: device drives combined carrier sense/data valid on valid pin
// - rgmii: device drives receive control on the data valid pin
// - port 7 data valid pin sampled as strap after resets before driving
// - mii: device drives receive error; unused in rmii/rgmii
// - mii carrier sense: output as phy, input as mac; unused otherwise
// - receive data four bits in mii/rgmii, two low bits in rmii
module mpmi_pins
  import mpmi_pkg::*;
(
  // core clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         arst_n_i,
  input  wire logic                         soft_rst_i,
  // per-port link clocks carrying the far party's transmit timing
  input  wire logic [mpmi_pkg::NPORTS-1:0]  link_clk_i,
  // static port configuration
  input  mpmi_pkg::mpmi_cfg_type [mpmi_pkg::NPORTS-1:0] cfg_i,
  // core side
  input  mpmi_pkg::mpmi_rx_type  [mpmi_pkg::NPORTS-1:0] core_rx_i,
  output mpmi_pkg::mpmi_tx_type  [mpmi_pkg::NPORTS-1:0] core_tx_o,
  output logic [mpmi_pkg::NPORTS-1:0]       core_tx_valid_o,
  output logic [mpmi_pkg::NPORTS-1:0]       core_col_o,
  output logic [mpmi_pkg::NPORTS-1:0]       core_crs_o,
  output logic                              strap_rx_ctl7_o,
  // transmit pins from the far party
  input  mpmi_pkg::mpmi_tx_type  [mpmi_pkg::NPORTS-1:0] tx_pin_i,
  output logic [mpmi_pkg::NPORTS-1:0]       tx_clk_o,
  output logic [mpmi_pkg::NPORTS-1:0]       tx_clk_oe_o,
  // receive clock pin
  output logic [mpmi_pkg::NPORTS-1:0]       rx_clk_o,
  output logic [mpmi_pkg::NPORTS-1:0]       rx_clk_oe_o,
  // data valid / carrier sense-valid / control pin
  input  wire logic [mpmi_pkg::NPORTS-1:0]  rx_ctl_i,
  output logic [mpmi_pkg::NPORTS-1:0]       rx_ctl_o,
  output logic [mpmi_pkg::NPORTS-1:0]       rx_ctl_oe_o,
  // receive error and data pins
  output logic [mpmi_pkg::NPORTS-1:0]       rx_er_o,
  output logic [mpmi_pkg::NPORTS-1:0]       rx_er_oe_o,
  output logic [mpmi_pkg::NPORTS-1:0][3:0]  rxd_o,
  output logic [mpmi_pkg::NPORTS-1:0][3:0]  rxd_oe_o,
  // collision and carrier sense pins
  input  wire logic [mpmi_pkg::NPORTS-1:0]  col_i,
  output logic [mpmi_pkg::NPORTS-1:0]       col_o,
  output logic [mpmi_pkg::NPORTS-1:0]       col_oe_o,
  input  wire logic [mpmi_pkg::NPORTS-1:0]  crs_i,
  output logic [mpmi_pkg::NPORTS-1:0]       crs_o,
  output logic [mpmi_pkg::NPORTS-1:0]       crs_oe_o
);
  import mpmi_pkg::*;

  // strap window: outputs stay released while the strap pin is sampled
  logic [WIN_W-1:0] win_cnt_ff;
  logic             win_open_ff;
  logic [1:0]       strap_sync_ff;
  logic             strap_ff;
  logic             soft_q_ff;
  logic [WIN_W-1:0] nxt_win_cnt;
  logic             win_last;

  assign win_last    = (win_cnt_ff == WIN_W'(STRAP_WIN_CY - 1));
  assign nxt_win_cnt = soft_q_ff ? '0 : (win_open_ff ? win_cnt_ff + 1'b1 : win_cnt_ff);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_q_ff     <= 1'b0;
      win_cnt_ff    <= '0;
      win_open_ff   <= 1'b1;
      strap_sync_ff <= 2'b00;
      strap_ff      <= 1'b0;
    end else begin
      soft_q_ff     <= soft_rst_i;
      win_cnt_ff    <= nxt_win_cnt;
      win_open_ff   <= soft_q_ff | (win_open_ff & ~win_last);
      strap_sync_ff <= {strap_sync_ff[0], rx_ctl_i[PORT7_IDX]};
      if (win_open_ff && win_last && !soft_q_ff) begin
        strap_ff <= strap_sync_ff[1];
      end
    end
  end

  assign strap_rx_ctl7_o = strap_ff;

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    mpmi_cfg_type     cfg_ff;
    logic             is_mii;
    logic             is_rmii;
    logic             is_rgmii;
    logic             mii_phy;
    logic [DIV_W-1:0] half;
    logic [DIV_W-1:0] div_cnt_ff;
    logic             gclk_ff;
    logic             tick;
    logic             fall;
    logic             drive;
    mpmi_rx_type      rx_ff;
    logic [3:0]       dmask;
    logic             ctl_val;

    // configuration is meant to be static; it is only registered, so pins
    // change direction when the configuration moves or when the strap window opens or closes
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cfg_ff <= CFG_RST;
      end else begin
        cfg_ff <= cfg_i[p];
      end
    end

    assign is_mii   = (cfg_ff.mode == MPMI_MII);
    assign is_rmii  = (cfg_ff.mode == MPMI_RMII);
    assign is_rgmii = (cfg_ff.mode == MPMI_RGMII);
    assign mii_phy  = is_mii & cfg_ff.phy_role;
    assign drive    = ~win_open_ff;
    assign dmask    = is_rmii ? D_LOW2 : D_ALL;

    // 125 mhz cannot be divided from the core clock; it rounds to one core
    // cycle per half period, so a real part would use a pll there
    assign half = is_rmii ? mpmi_half_cycles(RMII_REF_PS) :
                  (cfg_ff.speed == MPMI_SPD_1000) ? mpmi_half_cycles(RGMII_1G_PS) :
                  (cfg_ff.speed == MPMI_SPD_100) ? mpmi_half_cycles(MII_100_PS) :
                  mpmi_half_cycles(MII_10_PS);
    assign tick = (div_cnt_ff == '0);
    assign fall = tick & gclk_ff;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        div_cnt_ff <= '0;
        gclk_ff    <= 1'b0;
      end else begin
        div_cnt_ff <= tick ? half - 1'b1 : div_cnt_ff - 1'b1;
        gclk_ff    <= tick ? ~gclk_ff : gclk_ff;
      end
    end

    // data changes on the falling edge of the generated clock so it is
    // stable around the rising edge the far party samples on
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        rx_ff <= RX_RST;
      end else if (fall) begin
        rx_ff <= core_rx_i[p];
      end
    end

    assign ctl_val = is_rmii ? (rx_ff.crs | rx_ff.dv) : rx_ff.dv;

    // pin drivers and enables, all registered
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        tx_clk_o[p]    <= 1'b0;
        tx_clk_oe_o[p] <= 1'b0;
        rx_clk_o[p]    <= 1'b0;
        rx_clk_oe_o[p] <= 1'b0;
        rx_ctl_o[p]    <= 1'b0;
        rx_ctl_oe_o[p] <= 1'b0;
        rx_er_o[p]     <= 1'b0;
        rx_er_oe_o[p]  <= 1'b0;
        rxd_o[p]       <= 4'h0;
        rxd_oe_o[p]    <= 4'h0;
        col_o[p]       <= 1'b0;
        col_oe_o[p]    <= 1'b0;
        crs_o[p]       <= 1'b0;
        crs_oe_o[p]    <= 1'b0;
      end else begin
        tx_clk_o[p]    <= gclk_ff;
        tx_clk_oe_o[p] <= drive & mii_phy;
        rx_clk_o[p]    <= gclk_ff;
        rx_clk_oe_o[p] <= drive & (mii_phy | (is_rmii & cfg_ff.rmii_clk_mode) | is_rgmii);
        rx_ctl_o[p]    <= ctl_val;
        rx_ctl_oe_o[p] <= drive;
        rx_er_o[p]     <= rx_ff.er & is_mii;
        rx_er_oe_o[p]  <= drive & is_mii;
        rxd_o[p]       <= rx_ff.d & dmask;
        rxd_oe_o[p]    <= drive ? dmask : 4'h0;
        col_o[p]       <= rx_ff.col;
        col_oe_o[p]    <= drive & mii_phy;
        crs_o[p]       <= rx_ff.crs;
        crs_oe_o[p]    <= drive & mii_phy;
      end
    end

    // collision and carrier sense from an external phy, synchronised
    logic [1:0] col_sync_ff;
    logic [1:0] crs_sync_ff;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        col_sync_ff   <= 2'b00;
        crs_sync_ff   <= 2'b00;
        core_col_o[p] <= 1'b0;
        core_crs_o[p] <= 1'b0;
      end else begin
        col_sync_ff   <= {col_sync_ff[0], col_i[p]};
        crs_sync_ff   <= {crs_sync_ff[0], crs_i[p]};
        core_col_o[p] <= col_sync_ff[1] & is_mii & ~cfg_ff.phy_role;
        core_crs_o[p] <= crs_sync_ff[1] & is_mii & ~cfg_ff.phy_role;
      end
    end

    // link domain: capture each transmit word into one of two buffers so a
    // word stays stable for two link periods while the core picks it up
    mpmi_tx_type lbuf_ff [2];
    logic        lptr_ff;

    always_ff @(posedge link_clk_i[p] or negedge arst_n_i) begin
      if (!arst_n_i) begin
        lbuf_ff[0] <= TX_RST;
        lbuf_ff[1] <= TX_RST;
        lptr_ff    <= 1'b0;
      end else begin
        lbuf_ff[lptr_ff] <= tx_pin_i[p];
        lptr_ff          <= ~lptr_ff;
      end
    end

    // core side of the crossing: toggle pointer through two flip-flops
    logic [1:0]  ptr_sync_ff;
    logic        ptr_seen_ff;
    logic        new_word;
    mpmi_tx_type picked;
    mpmi_tx_type masked;

    assign new_word = (ptr_sync_ff[1] != ptr_seen_ff);
    assign picked   = lbuf_ff[ptr_seen_ff];
    assign masked   = '{en: picked.en,
                        er: picked.er & is_mii,
                        d:  picked.d & dmask};

    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ptr_sync_ff        <= 2'b00;
        ptr_seen_ff        <= 1'b0;
        core_tx_o[p]       <= TX_RST;
        core_tx_valid_o[p] <= 1'b0;
      end else begin
        ptr_sync_ff        <= {ptr_sync_ff[0], lptr_ff};
        ptr_seen_ff        <= ptr_sync_ff[1];
        core_tx_valid_o[p] <= new_word & drive;
        if (new_word) begin
          core_tx_o[p] <= masked;
        end
      end
    end
  end

endmodule : mpmi_pins

// file: src/mpmi_pkg.sv
// shared types and constants for the two external mac port pin multiplexers
package mpmi_pkg;

  localparam int unsigned NPORTS     = 2;
  localparam int unsigned PORT7_IDX  = 1;
  localparam int unsigned CORE_MHZ   = 200;
  localparam int unsigned CORE_PS    = 1000000 / CORE_MHZ;

  // link clock periods in picoseconds, as the nominal frequencies give them
  localparam int unsigned MII_100_PS   = 40000;
  localparam int unsigned MII_10_PS    = 400000;
  localparam int unsigned RMII_REF_PS  = 20000;
  localparam int unsigned RGMII_1G_PS  = 8000;

  // strap sampling window after any reset, in nanoseconds
  localparam int unsigned STRAP_WIN_NS = 100;
  localparam int unsigned STRAP_WIN_CY = (STRAP_WIN_NS * 1000 + CORE_PS - 1) / CORE_PS;

  localparam int unsigned DIV_W  = 6;
  localparam int unsigned WIN_W  = 8;

  typedef enum logic [1:0] {
    MPMI_MII,
    MPMI_RMII,
    MPMI_RGMII
  } mpmi_mode_type;

  typedef enum logic [1:0] {
    MPMI_SPD_10,
    MPMI_SPD_100,
    MPMI_SPD_1000
  } mpmi_speed_type;

  typedef struct packed {
    mpmi_mode_type  mode;
    logic           phy_role;
    logic           rmii_clk_mode;
    mpmi_speed_type speed;
  } mpmi_cfg_type;

  // word the far party transmits into the device
  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] d;
  } mpmi_tx_type;

  // word the device presents towards the far party
  typedef struct packed {
    logic       dv;
    logic       er;
    logic       crs;
    logic       col;
    logic [3:0] d;
  } mpmi_rx_type;

  localparam mpmi_cfg_type CFG_RST   = '{mode: MPMI_MII, phy_role: 1'b0,
                                         rmii_clk_mode: 1'b0, speed: MPMI_SPD_100};
  localparam mpmi_tx_type  TX_RST    = '0;
  localparam mpmi_rx_type  RX_RST    = '0;
  localparam logic [3:0]   D_ALL     = 4'hf;
  localparam logic [3:0]   D_LOW2    = 4'h3;

  // half period of a generated clock in core cycles, rounded down, never below one
  function automatic logic [DIV_W-1:0] mpmi_half_cycles(input int unsigned period_ps);
    int unsigned n;
    n = period_ps / (2 * CORE_PS);
    if (n < 1) begin
      n = 1;
    end
    return n[DIV_W-1:0];
  endfunction : mpmi_half_cycles

endpackage : mpmi_pkg

// file: test/mpmi_pins_properties.sv
// concurrent checks on the pin multiplexer ports, port 6 lane, plus both valid pins after reset
module mpmi_pins_chk
  import mpmi_pkg::*;
(
  // clock and reset
  input wire logic                    clock_i,
  input wire logic                    arst_n_i,
  // watched ports
  input wire mpmi_pkg::mpmi_cfg_type [1:0] cfg_i,
  input wire mpmi_pkg::mpmi_tx_type [1:0]  core_tx_o,
  input wire logic [1:0]              core_tx_valid_o,
  input wire logic [1:0]              core_col_o,
  input wire logic [1:0]              tx_clk_oe_o,
  input wire logic [1:0]              rx_clk_oe_o,
  input wire logic [1:0]              rx_ctl_oe_o,
  input wire logic [1:0]              rx_er_oe_o,
  input wire logic [1:0][3:0]         rxd_oe_o,
  input wire logic [1:0]              col_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic is_mii;
  logic is_rmii;
  logic phy;
  assign is_mii  = cfg_i[0].mode == MPMI_MII;
  assign is_rmii = cfg_i[0].mode == MPMI_RMII;
  assign phy     = cfg_i[0].phy_role;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_txclk_oe_role: assert property (tx_clk_oe_o[0] |-> is_mii && phy)
    else $error("tx clock driven outside mii phy role");
  a_rxclk_oe_mode: assert property (rx_clk_oe_o[0] |-> (is_mii && phy) ||
    (is_rmii && cfg_i[0].rmii_clk_mode) || cfg_i[0].mode == MPMI_RGMII)
    else $error("rx clock driven in wrong mode");
  a_rxer_mii_only: assert property (rx_er_oe_o[0] |-> is_mii)
    else $error("rx error driven outside mii");
  a_rxd_lane_width: assert property (|rxd_oe_o[0] |-> rxd_oe_o[0] == (is_rmii ? D_LOW2 : D_ALL))
    else $error("rx data lane width wrong");
  a_col_phy_only: assert property (col_oe_o[0] |-> is_mii && phy)
    else $error("collision driven outside mii phy role");
  a_col_mac_sense: assert property (core_col_o[0] |-> is_mii && !phy)
    else $error("collision sensed outside mii mac role");
  a_strap_quiet: assert property ($rose(arst_n_i) |-> (rx_ctl_oe_o == 2'b00) [*8])
    else $error("valid pin driven during strap window");
  a_txer_masked: assert property (core_tx_o[0].er |-> is_mii)
    else $error("tx error passed outside mii");
  a_txd_low_two: assert property (is_rmii |-> core_tx_o[0].d[3:2] == 2'b00)
    else $error("upper tx data passed in rmii");
  a_valid_pulse: assert property (core_tx_valid_o[0] |=> !core_tx_valid_o[0])
    else $error("tx valid longer than one cycle");
endmodule : mpmi_pins_chk

bind mpmi_pins mpmi_pins_chk u_mpmi_pins_chk (.clock_i, .arst_n_i, .cfg_i, .core_tx_o,
  .core_tx_valid_o, .core_col_o, .tx_clk_oe_o, .rx_clk_oe_o, .rx_ctl_oe_o, .rx_er_oe_o,
  .rxd_oe_o, .col_oe_o);

// file: test/mpmi_far.sv
// far party model: mac or phy feeding the transmit pins of both ports
module mpmi_far
  import mpmi_pkg::*;
(
  input  wire logic                   link_clk_i,
  input  wire mpmi_pkg::mpmi_cfg_type [1:0] cfg_i,
  output mpmi_pkg::mpmi_tx_type [1:0] tx_pin_o,
  output logic [1:0]                  col_o,
  output logic [1:0]                  crs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial tx_pin_o = '0;
  // unconnected pins sit at their pull-down, so unused bits read zero
  always @(posedge link_clk_i) begin
    for (int p = 0; p < 2; p++) begin
      tx_pin_o[p].en <= 1'b1;
      tx_pin_o[p].er <= cfg_i[p].mode == MPMI_MII;
      tx_pin_o[p].d  <= (cfg_i[p].mode == MPMI_RMII) ? 4'h2 : 4'h9;
    end
  end
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      col_o[p] = cfg_i[p].mode == MPMI_MII && !cfg_i[p].phy_role;
      crs_o[p] = col_o[p];
    end
  end
endmodule : mpmi_far

// file: test/mpmi_pins_test.sv
// self-checking bench for the port pin multiplexer
module mpmi_pins_test
  import mpmi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, lclk = 0, arst_n_i = 0, soft_rst_i = 0;
  mpmi_cfg_type [1:0] cfg = '0;
  // valid low with carrier, error and collision high, nibble c: only the rmii
  // combined valid pin may show a one
  mpmi_rx_type [1:0] core_rx = {2{8'h7c}};
  mpmi_tx_type [1:0] core_tx, tx_pin;
  logic [1:0] tx_valid, col_c, crs_c, tx_clk, tx_clk_oe, rx_clk, rx_clk_oe, rx_ctl;
  logic [1:0] rx_ctl_oe, rx_er, rx_er_oe, col_pin, col_oe, crs_pin, crs_oe, far_col, far_crs;
  logic [1:0] strap_lvl = 2'b00;
  logic [1:0][3:0] rxd, rxd_oe;
  logic strap7;
  int err_total = 0, checks_done = 0, cyc = 0;
  wire [1:0] rx_ctl_in = (rx_ctl_oe & rx_ctl) | (~rx_ctl_oe & strap_lvl);
  wire [1:0] col_in = (col_oe & col_pin) | (~col_oe & far_col);
  wire [1:0] crs_in = (crs_oe & crs_pin) | (~crs_oe & far_crs);
  always #2.5 clock_i = ~clock_i;
  // link clock of the far party, phase unrelated to the core clock
  initial begin
    #1.3;
    forever #6 lclk = ~lclk;
  end
  mpmi_pins u_mpmi_pins (.clock_i, .arst_n_i, .soft_rst_i, .link_clk_i({2{lclk}}), .cfg_i(cfg),
    .core_rx_i(core_rx), .core_tx_o(core_tx), .core_tx_valid_o(tx_valid), .core_col_o(col_c),
    .core_crs_o(crs_c), .strap_rx_ctl7_o(strap7), .tx_pin_i(tx_pin), .tx_clk_o(tx_clk),
    .tx_clk_oe_o(tx_clk_oe), .rx_clk_o(rx_clk), .rx_clk_oe_o(rx_clk_oe), .rx_ctl_i(rx_ctl_in),
    .rx_ctl_o(rx_ctl), .rx_ctl_oe_o(rx_ctl_oe), .rx_er_o(rx_er), .rx_er_oe_o(rx_er_oe),
    .rxd_o(rxd), .rxd_oe_o(rxd_oe), .col_i(col_in), .col_o(col_pin), .col_oe_o(col_oe),
    .crs_i(crs_in), .crs_o(crs_pin), .crs_oe_o(crs_oe));
  mpmi_far u_mpmi_far (.link_clk_i(lclk), .cfg_i(cfg), .tx_pin_o(tx_pin), .col_o(far_col),
    .crs_o(far_crs));
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end
  task automatic do_reset(input mpmi_cfg_type c, input logic [1:0] s);
    @(posedge clock_i) #1;
    arst_n_i = 0;
    cfg = {2{c}};
    strap_lvl = s;
    repeat (3) @(posedge clock_i);
    #1 arst_n_i = 1;
    repeat (10) @(posedge clock_i);
    #1;
    chk(rx_ctl_oe === 2'b00, "valid pin driven in strap window");
    repeat (STRAP_WIN_CY) @(posedge clock_i);
    #1;
  endtask : do_reset
  // one mode: pin directions, masking and clock rates; half is the generated half period
  task automatic t_mode(input mpmi_cfg_type c, input logic tx_oe, rx_oe, input logic [3:0] d_oe,
                        input logic er_oe, input int half);
    int rises, tx_rises, vals, want;
    logic mii, mac, prev_rx, prev_tx;
    mii = c.mode == MPMI_MII;
    mac = mii && !c.phy_role;
    rises = 0;
    tx_rises = 0;
    vals = 0;
    want = 120 / (2 * half);
    do_reset(c, 2'b00);
    prev_rx = rx_clk[0];
    prev_tx = tx_clk[0];
    for (int i = 0; i < 120; i++) begin
      @(posedge clock_i) #1;
      if (rx_clk[0] === 1'b1 && prev_rx === 1'b0) rises++;
      if (tx_clk[0] === 1'b1 && prev_tx === 1'b0) tx_rises++;
      prev_rx = rx_clk[0];
      prev_tx = tx_clk[0];
      vals += tx_valid[0];
    end
    chk(tx_clk_oe[0] === tx_oe, "tx clock direction");
    chk(rx_clk_oe[0] === rx_oe, "rx clock direction");
    if (rx_oe) chk(rises >= want - 1 && rises <= want + 1, "rx clock rate");
    chk(!tx_oe || (tx_rises >= want - 1 && tx_rises <= want + 1), "tx clock rate");
    chk(vals >= 48 && vals <= 51, "tx word rate");
    chk(rx_ctl_oe === 2'b11 && rx_ctl[0] === (c.mode == MPMI_RMII), "valid pin");
    chk(rxd_oe[0] === d_oe && rxd[0] === (4'hc & d_oe), "rx data lanes");
    chk(rx_er_oe[0] === er_oe && rx_er[0] === er_oe, "rx error pin");
    chk(col_oe[0] === (mii && !mac) && col_c[0] === mac, "collision pin");
    chk(crs_oe[0] === (mii && !mac) && crs_c[0] === mac, "carrier pin");
    chk(core_tx[0] === {1'b1, mii, (c.mode == MPMI_RMII) ? 4'h2 : 4'h9}, "tx word");
  endtask : t_mode
  task automatic t_strap;
    do_reset(mpmi_cfg_type'{MPMI_MII, 1'b1, 1'b0, MPMI_SPD_100}, 2'b10);
    chk(strap7 === 1'b1, "strap high");
    strap_lvl = 2'b00;
    soft_rst_i = 1;
    @(posedge clock_i) #1 soft_rst_i = 0;
    repeat (4) @(posedge clock_i);
    #1;
    chk(rx_ctl_oe === 2'b00, "valid pin after soft reset");
    repeat (STRAP_WIN_CY + 2) @(posedge clock_i);
    #1 chk(strap7 === 1'b0 && rx_ctl_oe === 2'b11, "strap low");
  endtask : t_strap
  initial begin
    t_mode(mpmi_cfg_type'{MPMI_MII, 1'b1, 1'b0, MPMI_SPD_100}, 1, 1, 4'hf, 1, 4);
    t_mode(mpmi_cfg_type'{MPMI_MII, 1'b0, 1'b0, MPMI_SPD_10}, 0, 0, 4'hf, 1, 40);
    t_mode(mpmi_cfg_type'{MPMI_RMII, 1'b0, 1'b0, MPMI_SPD_100}, 0, 0, 4'h3, 0, 2);
    t_mode(mpmi_cfg_type'{MPMI_RMII, 1'b0, 1'b1, MPMI_SPD_100}, 0, 1, 4'h3, 0, 2);
    t_mode(mpmi_cfg_type'{MPMI_RGMII, 1'b0, 1'b0, MPMI_SPD_1000}, 0, 1, 4'hf, 0, 1);
    t_strap();
    close_out();
  end
endmodule : mpmi_pins_test
